// *** design/jtbs_cfg.svh ***
// Constants of the boundary-scan test access port.
`ifndef JTBS_CFG_SVH
`define JTBS_CFG_SVH

// Instruction register width, opcodes and the capture pattern.
`define JTBS_IR_W          6
`define JTBS_OP_EXTEST     6'h00
`define JTBS_OP_SAMPLE     6'h01
`define JTBS_OP_IDCODE     6'h02
`define JTBS_OP_HIGHZ      6'h03
`define JTBS_OP_CLAMP      6'h3e
`define JTBS_OP_BYPASS     6'h3f
`define JTBS_IR_CAPTURE    6'h2d

// Identification register; the code value is arbitrary.
`define JTBS_ID_W          32
`define JTBS_IDCODE_DFLT   32'h0a5a_5001

// Pin counts of each cell kind.
`define JTBS_N_RX          14
`define JTBS_N_SYS         5
`define JTBS_N_TX          7
`define JTBS_N_BIDI        8
`define JTBS_N_PADIN       27

// Boundary chain layout, bit 0 nearest the serial output.
`define JTBS_BSR_LEN       42
`define JTBS_RX_BASE       0
`define JTBS_SYS_BASE      14
`define JTBS_TX_BASE       19
`define JTBS_CAP_BASE      26
`define JTBS_OE_BASE       34

// Consecutive mode-select ones that always end in reset.
`define JTBS_TLR_ONES      3'h5

// Depth of the instruction report buffer.
`define JTBS_BUF_DEPTH     2

`endif

// *** design/jtbs_pkg.sv ***
// Types of the boundary-scan test access port.
package jtbs_pkg;

  // Sixteen controller states.
  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR,
    S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
  } jtbs_state_t;

  // Data register selected between the serial input and output.
  typedef enum logic [1:0] {
    DR_BYPASS, DR_IDCODE, DR_BOUNDARY
  } jtbs_dr_t;

endpackage : jtbs_pkg

// *** design/jtbs_buf.sv ***
// Two-entry valid/ready buffer built from flip-flops.
module jtbs_buf #(
  parameter int W     = 6,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  import jtbs_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  // Honest full and empty flags derived from the fill count.
  assign in_ready_o  = (count < (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage written at the write index.
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap over the depth.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  // Fill count follows pushes and pops.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      count <= '0;
    else
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
  end

endmodule : jtbs_buf

// *** design/jtbs_tap.sv ***
// Boundary-scan test access port with controller, instruction and data registers.
`include "jtbs_cfg.svh"

// Contract
// - Sixteen-state controller driven through five dedicated test pins.
// - Instruction register is six bits; all decoding uses those six bits.
// - Test reset pin low resets the controller without any test clock edge.
// - Mode select and serial input are sampled on test clock rising edges.
// - Serial output changes on test clock falling edges.
// - Serial output is driven only while shifting data or instruction.
// - State moves by mode select sampled at each rising edge; tester sets it.
// - Reset state reached by reset pin or five consecutive mode-select ones.
// - Serial input feeds whichever register is selected.
// - Boundary logic follows the standard for the DC-coupled pins.
// - No AC-coupled test mode or its instructions exist.
// - Tester can read the part number through the identification path.
// - Observe cells on receive, control on transmit, both on two-way pins.
// - Opcodes: extest, sample, idcode, highz, clamp, bypass as listed.
// - Instruction capture loads 101101.
// - Shifted instruction takes effect only in the update state.
// - Two-way capture takes core data when enabled and not extest.
module jtbs_tap #(
  parameter logic [`JTBS_ID_W-1:0] IDCODE = `JTBS_IDCODE_DFLT
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    tck_i,
  input  wire logic                    tms_i,
  input  wire logic                    tdi_i,
  input  wire logic                    trst_b_i,
  output logic                         tdo_o,
  output logic                         tdo_oe_o,
  input  wire logic [`JTBS_N_RX-1:0]   rx_pad_i,
  input  wire logic [`JTBS_N_SYS-1:0]  sys_pad_i,
  input  wire logic [`JTBS_N_TX-1:0]   tx_core_i,
  output logic      [`JTBS_N_TX-1:0]   tx_pad_o,
  output logic      [`JTBS_N_TX-1:0]   tx_pad_oe_o,
  input  wire logic [`JTBS_N_BIDI-1:0] bidi_core_out_i,
  input  wire logic [`JTBS_N_BIDI-1:0] bidi_core_oe_i,
  input  wire logic [`JTBS_N_BIDI-1:0] bidi_pad_i,
  output logic      [`JTBS_N_BIDI-1:0] bidi_pad_o,
  output logic      [`JTBS_N_BIDI-1:0] bidi_pad_oe_o,
  output logic      [`JTBS_IR_W-1:0]   instr_o,
  output logic                         instr_valid_o,
  input  wire logic                    instr_ready_i
);
  import jtbs_pkg::*;

  localparam int NIN = 3 + `JTBS_N_PADIN;

  logic [NIN-1:0]              sync1;
  logic [NIN-1:0]              sync2;
  logic                        tck_d;
  logic                        rise;
  logic                        fall;
  logic                        tms_s;
  logic                        tdi_s;
  logic [`JTBS_N_RX-1:0]       rx_s;
  logic [`JTBS_N_SYS-1:0]      sys_s;
  logic [`JTBS_N_BIDI-1:0]     bidi_s;
  logic                        tap_arst_b;
  logic                        rs1;
  logic                        tap_rst_b;
  jtbs_state_t                 state;
  logic [`JTBS_IR_W-1:0]       ir_sr;
  logic [`JTBS_IR_W-1:0]       instr;
  logic                        byp;
  logic [`JTBS_ID_W-1:0]       id_sr;
  logic [`JTBS_BSR_LEN-1:0]    bsr;
  logic [`JTBS_BSR_LEN-1:0]    bsu;
  logic [`JTBS_BSR_LEN-1:0]    cap;
  jtbs_dr_t                    sel;
  logic                        extest;
  logic                        test_mode;
  logic                        highz;
  logic                        push_pend;
  logic                        push_ready;
  logic [2:0]                  ones_cnt;

  // Next controller state for a sampled mode-select value.
  function automatic jtbs_state_t tap_next(input jtbs_state_t s, input logic m);
    case (s)
      S_TLR:    tap_next = m ? S_TLR    : S_RTI;
      S_RTI:    tap_next = m ? S_SEL_DR : S_RTI;
      S_SEL_DR: tap_next = m ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: tap_next = m ? S_EX1_DR : S_SH_DR;
      S_SH_DR:  tap_next = m ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: tap_next = m ? S_UPD_DR : S_PA_DR;
      S_PA_DR:  tap_next = m ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: tap_next = m ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: tap_next = m ? S_SEL_DR : S_RTI;
      S_SEL_IR: tap_next = m ? S_TLR    : S_CAP_IR;
      S_CAP_IR: tap_next = m ? S_EX1_IR : S_SH_IR;
      S_SH_IR:  tap_next = m ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: tap_next = m ? S_UPD_IR : S_PA_IR;
      S_PA_IR:  tap_next = m ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: tap_next = m ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: tap_next = m ? S_SEL_DR : S_RTI;
      default:  tap_next = S_TLR;
    endcase
  endfunction : tap_next

  // Data register chosen by a six-bit opcode; AC-coupled opcodes do not exist.
  function automatic jtbs_dr_t dr_sel(input logic [`JTBS_IR_W-1:0] op);
    case (op)
      `JTBS_OP_EXTEST, `JTBS_OP_SAMPLE: dr_sel = DR_BOUNDARY;
      `JTBS_OP_IDCODE:                  dr_sel = DR_IDCODE;
      default:                          dr_sel = DR_BYPASS;
    endcase
  endfunction : dr_sel

  // Two-flop synchronisers on every input from outside the clock domain.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {tck_i, tms_i, tdi_i, bidi_pad_i, sys_pad_i, rx_pad_i};
      sync2 <= sync1;
    end
  end

  assign {tms_s, tdi_s, bidi_s, sys_s, rx_s} = sync2[NIN-2:0];

  // Test clock edges found by the system clock.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tck_d <= 1'b0;
    else
      tck_d <= sync2[NIN-1];
  end

  assign rise = sync2[NIN-1] && !tck_d;
  assign fall = !sync2[NIN-1] && tck_d;

  assign tap_arst_b = rst_b_i && trst_b_i;

  // Reset asserts at once and releases on the system clock.
  always_ff @(posedge clk_i or negedge tap_arst_b)
  begin
    if (!tap_arst_b)
    begin
      rs1       <= 1'b0;
      tap_rst_b <= 1'b0;
    end
    else
    begin
      rs1       <= 1'b1;
      tap_rst_b <= rs1;
    end
  end

  always_ff @(posedge clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
      state <= S_TLR;
    else if (rise)
      state <= tap_next(state, tms_s);
  end

  always_ff @(posedge clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
      ir_sr <= `JTBS_IR_CAPTURE;
    else if (rise && state == S_CAP_IR)
      ir_sr <= `JTBS_IR_CAPTURE;
    else if (rise && state == S_SH_IR)
      ir_sr <= {tdi_s, ir_sr[`JTBS_IR_W-1:1]};
  end

  // instruction updates on the falling edge in the update state.
  always_ff @(posedge clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
      instr <= `JTBS_OP_IDCODE;
    else if (state == S_TLR)
      instr <= `JTBS_OP_IDCODE;
    else if (fall && state == S_UPD_IR)
      instr <= ir_sr;
  end

  assign sel       = dr_sel(instr);
  assign extest    = (instr == `JTBS_OP_EXTEST);
  assign test_mode = extest || (instr == `JTBS_OP_CLAMP);
  assign highz     = (instr == `JTBS_OP_HIGHZ);

  always_ff @(posedge clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
      byp <= 1'b0;
    else if (rise && state == S_CAP_DR && sel == DR_BYPASS)
      byp <= 1'b0;
    else if (rise && state == S_SH_DR && sel == DR_BYPASS)
      byp <= tdi_s;
  end

  always_ff @(posedge clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
      id_sr <= '0;
    else if (rise && state == S_CAP_DR && sel == DR_IDCODE)
      id_sr <= {IDCODE[`JTBS_ID_W-1:1], 1'b1};
    else if (rise && state == S_SH_DR && sel == DR_IDCODE)
      id_sr <= {tdi_s, id_sr[`JTBS_ID_W-1:1]};
  end

  // cell capture values per kind of pin
  generate
    for (genvar i = 0; i < `JTBS_N_RX; i++)
    begin : g_rx
      assign cap[`JTBS_RX_BASE + i] = rx_s[i];
    end
    for (genvar i = 0; i < `JTBS_N_SYS; i++)
    begin : g_sys
      assign cap[`JTBS_SYS_BASE + i] = sys_s[i];
    end
    for (genvar i = 0; i < `JTBS_N_TX; i++)
    begin : g_tx
      assign cap[`JTBS_TX_BASE + i] = tx_core_i[i];
    end
    for (genvar i = 0; i < `JTBS_N_BIDI; i++)
    begin : g_bidi
      assign cap[`JTBS_CAP_BASE + i] = (bidi_core_oe_i[i] && !extest) ? bidi_core_out_i[i]
                                                                    : bidi_s[i];
      assign cap[`JTBS_OE_BASE + i]  = bidi_core_oe_i[i];
    end
  endgenerate

  // Boundary shift register; capture, shift and falling-edge update.
  always_ff @(posedge clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
      bsr <= '0;
    else if (rise && state == S_CAP_DR && sel == DR_BOUNDARY)
      bsr <= cap;
    else if (rise && state == S_SH_DR && sel == DR_BOUNDARY)
      bsr <= {tdi_s, bsr[`JTBS_BSR_LEN-1:1]};
  end

  always_ff @(posedge clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
      bsu <= '0;
    else if (fall && state == S_UPD_DR && sel == DR_BOUNDARY)
      bsu <= bsr;
  end

  // only DC levels reach the pads; no time-varying test signalling.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_pad_o      <= '0;
      tx_pad_oe_o   <= '0;
      bidi_pad_o    <= '0;
      bidi_pad_oe_o <= '0;
    end
    else
    begin
      tx_pad_o      <= test_mode ? bsu[`JTBS_TX_BASE +: `JTBS_N_TX] : tx_core_i;
      tx_pad_oe_o   <= {`JTBS_N_TX{!highz}};
      bidi_pad_o    <= test_mode ? bsu[`JTBS_CAP_BASE +: `JTBS_N_BIDI] : bidi_core_out_i;
      bidi_pad_oe_o <= highz ? '0
                     : test_mode ? bsu[`JTBS_OE_BASE +: `JTBS_N_BIDI] : bidi_core_oe_i;
    end
  end

  // serial output on the falling edge
  always_ff @(posedge clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (fall)
    begin
      tdo_oe_o <= (state == S_SH_DR) || (state == S_SH_IR);
      if (state == S_SH_IR)
        tdo_o <= ir_sr[0];
      else if (sel == DR_IDCODE)
        tdo_o <= id_sr[0];
      else if (sel == DR_BOUNDARY)
        tdo_o <= bsr[0];
      else
        tdo_o <= byp;
    end
  end

  // An instruction loaded in the update state is reported; a full buffer keeps the report pending, and a later load replaces its value.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      push_pend <= 1'b0;
    else if (fall && state == S_UPD_IR)
      push_pend <= 1'b1;
    else if (push_ready)
      push_pend <= 1'b0;
  end

  jtbs_buf #(
    .W     (`JTBS_IR_W),
    .DEPTH (`JTBS_BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push_pend),
    .in_ready_o  (push_ready),
    .in_data_i   (instr),
    .out_valid_o (instr_valid_o),
    .out_ready_i (instr_ready_i),
    .out_data_o  (instr_o)
  );

  // Helper count of consecutive rising edges with mode select high.
  always_ff @(posedge clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
      ones_cnt <= '0;
    else if (rise)
      ones_cnt <= !tms_s ? 3'h0 : (ones_cnt == `JTBS_TLR_ONES) ? ones_cnt : ones_cnt + 3'h1;
  end

  sequence s_cap_ir;
    rise && state == S_CAP_IR;
  endsequence

  sequence s_upd_ir;
    fall && state == S_UPD_IR;
  endsequence

  property p_trst;
    @(posedge clk_i) disable iff (!rst_b_i) !trst_b_i |=> state == S_TLR;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset did not reset");

  property p_five_ones;
    @(posedge clk_i) disable iff (!tap_rst_b) ones_cnt == `JTBS_TLR_ONES |-> state == S_TLR;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("five ones missed reset");

  property p_leave_tlr;
    @(posedge clk_i) disable iff (!tap_rst_b)
      rise && state == S_TLR && !tms_s |=> state == S_RTI;
  endproperty
  a_leave_tlr: assert property (p_leave_tlr) else $error("bad exit from reset");

  property p_ir_cap;
    @(posedge clk_i) disable iff (!tap_rst_b) s_cap_ir |=> ir_sr == `JTBS_IR_CAPTURE;
  endproperty
  a_ir_cap: assert property (p_ir_cap) else $error("capture pattern wrong");

  property p_ir_upd;
    @(posedge clk_i) disable iff (!tap_rst_b)
      s_upd_ir ##0 (ir_sr != instr) |=> instr == $past(ir_sr) && push_pend;
  endproperty
  a_ir_upd: assert property (p_ir_upd) else $error("instruction not updated");

  property p_ir_hold;
    @(posedge clk_i) disable iff (!tap_rst_b)
      $changed(instr) |-> $past(state) inside {S_UPD_IR, S_TLR};
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instruction changed early");

  property p_tdo_fall;
    @(posedge clk_i) disable iff (!tap_rst_b) $changed(tdo_o) |-> $past(fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("output moved off edge");

  property p_tdo_oe;
    @(posedge clk_i) disable iff (!tap_rst_b)
      $rose(tdo_oe_o) |-> $past(state) inside {S_SH_DR, S_SH_IR};
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("output driven outside shift");

  property p_tlr_id;
    @(posedge clk_i) disable iff (!tap_rst_b) state == S_TLR |=> instr == `JTBS_OP_IDCODE;
  endproperty
  a_tlr_id: assert property (p_tlr_id) else $error("reset did not select id");

  property p_byp;
    @(posedge clk_i) disable iff (!tap_rst_b)
      rise && state == S_SH_DR && sel == DR_BYPASS |=> byp == $past(tdi_s);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass did not shift");

endmodule : jtbs_tap

// *** test/jtbs_tester.sv ***
// Model of the external test controller that drives the test pins.
module jtbs_tester (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_b_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic last = 1'b0;
  logic tdo_w;

  // A released output shows the inverse of its last driven level.
  always_ff @(posedge clk_i)
  begin
    if (tdo_oe_i)
    begin
      last <= tdo_i;
    end
  end
  assign tdo_w = tdo_oe_i ? tdo_i : ~last;

  // Pins start with the test clock stopped low and test reset held.
  initial
  begin
    tck_o    = 1'b0;
    tms_o    = 1'b1;
    tdi_o    = 1'b1;
    trst_b_o = 1'b0;
  end

  // One test clock period of 5 clk low and 3 clk high; output read before the rise.
  // mode set early
  task automatic step(input logic m, input logic d, output logic q, output logic e);
    @(posedge clk_i);
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_i);
    q = tdo_w;
    e = tdo_oe_i;
    tck_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask : step

  // Applies n mode-select bits, lowest first.
  // ones reach reset
  task automatic walk(input logic [7:0] s, input int n);
    logic q;
    logic e;
    for (int i = 0; i < n; i++)
    begin
      step(s[i], 1'b0, q, e);
    end
  endtask : walk

  // Idle to capture, n shifts, update, idle; ok drops on a wrong output enable.
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout, output logic ok);
    logic q;
    logic e;
    dout = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 3 : 2);
    step(1'b0, 1'b0, q, e);
    ok = ~e;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q, e);
      dout[i] = q;
      ok &= e;
    end
    walk(8'h01, 2);
  endtask : scan

  // Sets the test reset pin.
  task automatic set_trst(input logic v);
    @(posedge clk_i);
    trst_b_o <= v;
  endtask : set_trst
endmodule : jtbs_tester

// *** test/jtbs_tap_bench.sv ***
// Self-checking bench of the boundary-scan test access port.
`include "jtbs_cfg.svh"
module jtbs_tap_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        trst_b;
  logic        tdo;
  logic        tdo_oe;
  logic [13:0] rx_pad = 14'h0;
  logic [4:0]  sys_pad = 5'h0;
  logic [6:0]  tx_core = 7'h2a;
  logic [6:0]  tx_pad;
  logic [6:0]  tx_pad_oe;
  logic [7:0]  bidi_core_out = 8'h0;
  logic [7:0]  bidi_core_oe = 8'h0;
  logic [7:0]  bidi_pad = 8'h0;
  logic [7:0]  bidi_pad_o;
  logic [7:0]  bidi_pad_oe;
  logic [5:0]  instr;
  logic        instr_valid;
  logic        instr_ready = 1'b0;
  int          err_count = 0;
  int          compares = 0;

  // Clock of 50 ns period.
  initial
  begin
    forever #25 clk = ~clk;
  end

  jtbs_tap i_jtbs_tap (
    .clk_i(clk), .rst_b_i(rst_b), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_b_i(trst_b), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .rx_pad_i(rx_pad),
    .sys_pad_i(sys_pad), .tx_core_i(tx_core), .tx_pad_o(tx_pad),
    .tx_pad_oe_o(tx_pad_oe), .bidi_core_out_i(bidi_core_out),
    .bidi_core_oe_i(bidi_core_oe), .bidi_pad_i(bidi_pad), .bidi_pad_o(bidi_pad_o),
    .bidi_pad_oe_o(bidi_pad_oe), .instr_o(instr), .instr_valid_o(instr_valid),
    .instr_ready_i(instr_ready)
  );

  jtbs_tester i_jtbs_tester (
    .clk_i(clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi), .trst_b_o(trst_b)
  );

  // Counts one comparison and reports a mismatch.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // Waits for a report, checks it and takes it with one ready pulse.
  task automatic drain(input logic [5:0] op);
    int k;
    k = 0;
    while (instr_valid !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 20)
    begin
      err_count++;
      finish_test();
    end
    check(instr, op);
    instr_ready <= 1'b1;
    @(posedge clk);
    instr_ready <= 1'b0;
    @(posedge clk);
  endtask : drain

  // Shifts an instruction in and checks the captured pattern.
  task automatic load_ir(input logic [5:0] op);
    logic [63:0] d;
    logic        ok;
    i_jtbs_tester.scan(1'b1, 6, {58'h0, op}, d, ok);
    check(d[5:0], `JTBS_IR_CAPTURE);
    check(ok, 1'b1);
  endtask : load_ir

  // Shifts n data bits through the selected register.
  task automatic dr(input int n, input logic [63:0] din, output logic [63:0] d);
    logic ok;
    i_jtbs_tester.scan(1'b0, n, din, d, ok);
    check(ok, 1'b1);
  endtask : dr

  // Identification register is selected after reset.
  task automatic t_idcode();
    logic [63:0] d;
    dr(40, 64'hab, d);
    check(d[39:0], {8'hab, `JTBS_IDCODE_DFLT});
    check(d[0], 1'b1);
    check(tdo_oe, 1'b0);
    $display("Test idcode done");
  endtask : t_idcode

  // Capture of receive, system and two-way data cells, then pads driven and released from the latches.
  task automatic t_boundary();
    logic [63:0] d;
    logic [63:0] din;
    din = {22'h0, 8'h0f, 8'ha5, 7'h55, 19'h0};
    @(posedge clk);
    rx_pad <= 14'h2a5c;
    sys_pad <= 5'h13;
    bidi_core_out <= 8'h3c;
    bidi_core_oe <= 8'h0f;
    bidi_pad <= 8'h96;
    load_ir(6'h01);
    drain(6'h01);
    dr(42, din, d);
    check(d[18:0], {5'h13, 14'h2a5c});
    check(d[33:26], 8'h9c);
    load_ir(6'h00);
    drain(6'h00);
    check(tx_pad, 7'h55);
    check({bidi_pad_oe, bidi_pad_o}, 16'h0fa5);
    dr(42, din, d);
    check(d[33:26], 8'h96);
    load_ir(6'h03);
    drain(6'h03);
    check({tx_pad_oe, bidi_pad_oe}, 15'h0);
    $display("Test boundary done");
  endtask : t_boundary

  // Every opcode and the reserved range edges select a register of the right length.
  task automatic t_ops();
    logic [5:0]  op [10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3e, 6'h3f,
                             6'h04, 6'h2c, 6'h2e, 6'h3d};
    int          len [10] = '{42, 42, 32, 1, 1, 1, 1, 1, 1, 1};
    logic [63:0] p;
    logic [63:0] d;
    p = 64'h0123_4567_89ab_cdef;
    for (int i = 0; i < 10; i++)
    begin
      load_ir(op[i]);
      drain(op[i]);
      dr(64, p, d);
      check(d >> len[i], p & ({64{1'b1}} >> len[i]));
      if (len[i] == 1)
        check(d[0], 1'b0);
      if (op[i] == 6'h3e)
        check(tx_pad, 7'h22);
    end
    $display("Test opcodes done");
  endtask : t_ops

  // Two reports wait while the receiver stalls, then leave in order.
  task automatic t_buf();
    load_ir(6'h01);
    load_ir(6'h3f);
    drain(6'h01);
    drain(6'h3f);
    repeat (2) @(posedge clk);
    check(instr_valid, 1'b0);
    $display("Test buffer done");
  endtask : t_buf

  // Reset by five mode ones from shifting, then by the pin in mid-shift.
  task automatic t_reset();
    logic [63:0] d;
    instr_ready <= 1'b1;
    load_ir(6'h3f);
    i_jtbs_tester.walk(8'h01, 3);
    i_jtbs_tester.walk(8'h1f, 6);
    dr(32, 64'h0, d);
    check(d[31:0], `JTBS_IDCODE_DFLT);
    load_ir(6'h3f);
    i_jtbs_tester.walk(8'h01, 3);
    repeat (5) @(posedge clk);
    check(tdo_oe, 1'b1);
    i_jtbs_tester.set_trst(1'b0);
    repeat (2) @(posedge clk);
    check(tdo_oe, 1'b0);
    i_jtbs_tester.set_trst(1'b1);
    repeat (6) @(posedge clk);
    i_jtbs_tester.walk(8'h00, 1);
    dr(32, 64'h0, d);
    check(d[31:0], `JTBS_IDCODE_DFLT);
    $display("Test reset done");
  endtask : t_reset

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    i_jtbs_tester.set_trst(1'b1);
    repeat (6) @(posedge clk);
    i_jtbs_tester.walk(8'h00, 1);
    t_idcode();
    t_boundary();
    t_ops();
    t_buf();
    t_reset();
    finish_test();
  end
endmodule : jtbs_tap_bench
